// File: core/output_on_off_delay_sequencer.sv
// Two-channel output turn-on / turn-off delay sequencer with its command registers.
// Assumes command strobes, page and enables are synchronous to core_clk_i and an
// external non-volatile store that loads and saves through the nvm ports.
`timescale 1ns/10ps
`include "seq_defs.svh"
module output_on_off_delay_sequencer
	import seq_pkg::*;
#(
	parameter int RAMP_CYCLES    = `RAMP_CYCLES,
	parameter int TON_MIN_CYCLES = `TON_MIN_CYCLES
)(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [1:0]  enable_i,
	input  wire logic [1:0]  follower_i,
	input  wire logic [1:0]  page_i,
	input  wire logic        cmd_wr_i,
	input  wire logic        cmd_rd_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] cmd_wdata_i,
	output logic      [15:0] cmd_rdata_o,
	output logic             cmd_rvalid_o,
	output logic             cmd_nack_o,
	input  wire logic        store_i,
	input  wire logic        nvm_load_i,
	input  wire logic [7:0]  nvm_seq1_i,
	input  wire logic [7:0]  nvm_seq2_i,
	input  wire logic [15:0] nvm_spare_i,
	output logic             nvm_wr_o,
	output logic      [7:0]  nvm_seq1_o,
	output logic      [7:0]  nvm_seq2_o,
	output logic      [15:0] nvm_spare_o,
	input  wire logic        valley_clk_en_i,
	input  wire logic [1:0]  valley_req_i,
	output logic      [1:0]  valley_active_o,
	output logic      [1:0]  output_en_o,
	output logic      [1:0]  soft_start_o,
	output logic      [1:0]  float_level_force_o,
	output logic      [11:0] trim_o
);
	localparam seq_state_t SEQ_RESET = '{
		ch:            '{CH_OFF, CH_OFF},
		on_code:       '{`SEQ_CODE_RESET, `SEQ_CODE_RESET},
		off_code:      '{`SEQ_CODE_RESET, `SEQ_CODE_RESET},
		spare_hi:      `SPARE_HI_RESET,
		trim:          `TRIM_RESET,
		nvm_spare:     16'h0000,
		rdata:         16'h0000,
		default:       '0
	};

	seq_state_t        s;
	seq_state_t        next_s;
	logic [1:0]        tmr_start;
	logic [1:0][2:0]   tmr_units;
	logic [1:0][31:0]  tmr_unit;
	logic [1:0]        tmr_done;
	logic [1:0]        sel;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] page_mask(input logic [1:0] page);
		case (page)
			`PAGE_CH1:  page_mask = 2'b01;
			`PAGE_CH2:  page_mask = 2'b10;
			`PAGE_BOTH: page_mask = 2'b11;
			default:    page_mask = 2'b00;
		endcase
	endfunction : page_mask

	// Unimplemented bits 4 and 0 are never stored and always read zero
	function automatic logic [7:0] pack_delay(input logic [2:0] on_c, input logic [2:0] off_c);
		pack_delay = {on_c, 1'b0, off_c, 1'b0};
	endfunction : pack_delay

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.soft_start = 2'b00;
		next_s.rvalid = 1'b0;
		next_s.nack = 1'b0;
		next_s.nvm_wr = 1'b0;
		tmr_start = 2'b00;
		tmr_units = '0;
		tmr_unit = '0;
		sel = page_mask(page_i);

		// Power-up image from the non-volatile store
		if (nvm_load_i) begin
			next_s.on_code[0] = nvm_seq1_i[`ON_CODE_MSB:`ON_CODE_LSB];
			next_s.off_code[0] = nvm_seq1_i[`OFF_CODE_MSB:`OFF_CODE_LSB];
			next_s.on_code[1] = nvm_seq2_i[`ON_CODE_MSB:`ON_CODE_LSB];
			next_s.off_code[1] = nvm_seq2_i[`OFF_CODE_MSB:`OFF_CODE_LSB];
			next_s.spare_hi = nvm_spare_i[`SPARE_HI_MSB:`SPARE_HI_LSB];
			next_s.trim = nvm_spare_i[11:0];
		end

		// ------------------------------------------------------------
		// Command writes; a write in the same cycle as a load wins
		// ------------------------------------------------------------
		if (cmd_wr_i) begin
			case (cmd_code_i)
				`CMD_SEQ_DELAY: begin
					if (sel == 2'b00) begin
						next_s.nack = 1'b1;
					end
					for (int c = 0; c < 2; c++) begin
						if (sel[c]) begin
							if (follower_i[c]) begin
								next_s.nack = 1'b1;
							end else begin
								next_s.on_code[c] = cmd_wdata_i[`ON_CODE_MSB:`ON_CODE_LSB];
								next_s.off_code[c] = cmd_wdata_i[`OFF_CODE_MSB:`OFF_CODE_LSB];
							end
						end
					end
				end
				`CMD_SPARE_WORD: begin
					// Trim bits are kept; only the top nibble is writable
					next_s.spare_hi = cmd_wdata_i[`SPARE_HI_MSB:`SPARE_HI_LSB];
				end
				default: begin
					next_s.nack = 1'b1;
				end
			endcase
		end

		// ------------------------------------------------------------
		// Command reads
		// ------------------------------------------------------------
		if (cmd_rd_i) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = 16'h0000;
			case (cmd_code_i)
				`CMD_SEQ_DELAY: begin
					if (sel[0] && !follower_i[0]) begin
						next_s.rdata = {8'h00, pack_delay(s.on_code[0], s.off_code[0])};
					end else if (sel == 2'b10 && !follower_i[1]) begin
						next_s.rdata = {8'h00, pack_delay(s.on_code[1], s.off_code[1])};
					end else begin
						next_s.nack = 1'b1;
					end
				end
				`CMD_SPARE_WORD: begin
					next_s.rdata = {s.spare_hi, s.trim};
				end
				default: begin
					next_s.nack = 1'b1;
				end
			endcase
		end

		// Saves the settings in force before this cycle's command
		if (store_i) begin
			next_s.nvm_wr = 1'b1;
			next_s.nvm_seq1 = pack_delay(s.on_code[0], s.off_code[0]);
			next_s.nvm_seq2 = pack_delay(s.on_code[1], s.off_code[1]);
			next_s.nvm_spare = {s.spare_hi, s.trim};
		end

		// ------------------------------------------------------------
		// Channel sequencing
		// ------------------------------------------------------------
		for (int c = 0; c < 2; c++) begin
			case (s.ch[c])
				CH_OFF: begin
					// Enable is level sensitive, so a request held through a turn-off is taken here
					if (enable_i[c]) begin
						if (follower_i[c]) begin
							next_s.ch[c] = CH_ON_WAIT;
							tmr_start[c] = 1'b1;
							tmr_units[c] = 3'h1;
							tmr_unit[c] = 32'(TON_MIN_CYCLES);
						end else if (s.on_code[c] == 3'h0) begin
							next_s.ch[c] = CH_RUN;
							next_s.soft_start[c] = 1'b1;
							next_s.output_en[c] = 1'b1;
						end else begin
							next_s.ch[c] = CH_ON_WAIT;
							tmr_start[c] = 1'b1;
							tmr_units[c] = s.on_code[c];
							tmr_unit[c] = 32'(RAMP_CYCLES);
						end
					end
				end
				CH_ON_WAIT: begin
					if (!enable_i[c]) begin
						// Abandoned turn-on; the timer finishes unseen
						next_s.ch[c] = CH_OFF;
					end else if (tmr_done[c]) begin
						next_s.ch[c] = CH_RUN;
						next_s.soft_start[c] = 1'b1;
						next_s.output_en[c] = 1'b1;
					end
				end
				CH_RUN: begin
					if (!enable_i[c]) begin
						if (follower_i[c] || s.off_code[c] == 3'h0) begin
							next_s.ch[c] = CH_OFF;
							next_s.output_en[c] = 1'b0;
						end else begin
							next_s.ch[c] = CH_OFF_WAIT;
							tmr_start[c] = 1'b1;
							tmr_units[c] = s.off_code[c];
							tmr_unit[c] = 32'(RAMP_CYCLES);
						end
					end
				end
				CH_OFF_WAIT: begin
					// Turn-on requests are not taken until the output is off
					if (tmr_done[c]) begin
						next_s.ch[c] = CH_OFF;
						next_s.output_en[c] = 1'b0;
					end
				end
				default: begin
					next_s.ch[c] = CH_OFF;
					next_s.output_en[c] = 1'b0;
				end
			endcase
		end

		// ------------------------------------------------------------
		// Adaptive valley limiter, stepped once per switching clock
		// ------------------------------------------------------------
		if (valley_clk_en_i) begin
			for (int c = 0; c < 2; c++) begin
				if (s.spare_hi[`SPARE_DIS_BIT]) begin
					next_s.valley_active[c] = valley_req_i[c];
					next_s.valley_block[c] = 1'b0;
					next_s.valley_cnt[c] = 2'd0;
				end else if (s.valley_block[c]) begin
					next_s.valley_active[c] = 1'b0;
					next_s.valley_cnt[c] = s.valley_cnt[c] + 2'd1;
					if (s.valley_cnt[c] == `VALLEY_BLOCK_LAST) begin
						next_s.valley_block[c] = 1'b0;
						next_s.valley_cnt[c] = 2'd0;
					end
				end else if (s.valley_active[c]) begin
					if (!valley_req_i[c]) begin
						next_s.valley_active[c] = 1'b0;
						next_s.valley_cnt[c] = 2'd0;
					end else if (s.valley_cnt[c] == `VALLEY_ACTIVE_LAST) begin
						next_s.valley_active[c] = 1'b0;
						next_s.valley_block[c] = 1'b1;
						next_s.valley_cnt[c] = 2'd0;
					end else begin
						next_s.valley_cnt[c] = s.valley_cnt[c] + 2'd1;
					end
				end else if (valley_req_i[c]) begin
					next_s.valley_active[c] = 1'b1;
					next_s.valley_cnt[c] = 2'd0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= SEQ_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Delay timers, one per channel
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_timer
		delay_timer u_timer (
			.core_clk_i    (core_clk_i),
			.nrst_i        (nrst_i),
			.start_i       (tmr_start[g]),
			.units_i       (tmr_units[g]),
			.unit_cycles_i (tmr_unit[g]),
			.busy_o        (),
			.done_o        (tmr_done[g])
		);
	end

	// ------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------
	assign cmd_rdata_o = s.rdata;
	assign cmd_rvalid_o = s.rvalid;
	assign cmd_nack_o = s.nack;
	assign nvm_wr_o = s.nvm_wr;
	assign nvm_seq1_o = s.nvm_seq1;
	assign nvm_seq2_o = s.nvm_seq2;
	assign nvm_spare_o = s.nvm_spare;
	assign valley_active_o = s.valley_active;
	assign output_en_o = s.output_en;
	assign soft_start_o = s.soft_start;
	assign float_level_force_o = {s.spare_hi[`SPARE_CH2_BIT], s.spare_hi[`SPARE_CH1_BIT]};
	assign trim_o = s.trim;

endmodule : output_on_off_delay_sequencer

// File: core/seq_defs.svh
// Constants of the output on/off delay sequencer: command codes, field positions,
// reset values and timing counts. Assumes a 100 MHz core clock.
// Operation
// - Enable high: wait turn-on code delay (bits 7:5) before soft-start begins.
// - Enable low: wait turn-off code delay (bits 3:1) before output disables.
// - Turn-off delay resets to zero, so output shuts off at once.
// - Delay register bits 4 and 0 ignore writes and read zero.
// - Delay equals code value times soft-start ramp time, 0 through 7.
// - Spare word top nibble sets valley duration and PWM float level per channel.
// - Spare word low bits are read-only trim; host writes ignored.
// - Spare word top nibble powers up as 3; store saves current settings.
// - Delay register paged: 0 channel 1, 1 channel 2, 11 both.
// - Follower channel ignores delay writes; on forced 50 us, off zero.
// - Valley limit enabled: event lasts at most 3 clocks, then blocked 2.
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define CMD_SPARE_WORD     8'he0
`define CMD_SEQ_DELAY      8'hd8

// ------------------------------------------------------------
// Page codes
// ------------------------------------------------------------
`define PAGE_CH1           2'b00
`define PAGE_CH2           2'b01
`define PAGE_BOTH          2'b11

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ON_CODE_MSB        7
`define ON_CODE_LSB        5
`define OFF_CODE_MSB       3
`define OFF_CODE_LSB       1
`define SPARE_HI_MSB       15
`define SPARE_HI_LSB       12
`define SPARE_DIS_BIT      2
`define SPARE_CH2_BIT      1
`define SPARE_CH1_BIT      0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SEQ_CODE_RESET     3'h0
`define SPARE_HI_RESET     4'h3
`define TRIM_RESET         12'h000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_MHZ            100
`define TON_MIN_US         50
`define TON_MIN_CYCLES     (`TON_MIN_US * `CLK_MHZ)
`define RAMP_TIME_US       1000
`define RAMP_CYCLES        (`RAMP_TIME_US * `CLK_MHZ)
`define VALLEY_ACTIVE_LAST 2'd2
`define VALLEY_BLOCK_LAST  2'd1

`endif

// File: core/seq_pkg.sv
// Types of the output on/off delay sequencer.
// Assumes seq_defs.svh for all numeric constants.
package seq_pkg;

	// ------------------------------------------------------------
	// Channel sequencing states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CH_OFF      = 4'b0001,
		CH_ON_WAIT  = 4'b0010,
		CH_RUN      = 4'b0100,
		CH_OFF_WAIT = 4'b1000
	} ch_state_t;

	// ------------------------------------------------------------
	// Whole state of the sequencer top
	// ------------------------------------------------------------
	typedef struct packed {
		ch_state_t [1:0]       ch;
		logic      [1:0][2:0]  on_code;
		logic      [1:0][2:0]  off_code;
		logic      [3:0]       spare_hi;
		logic      [11:0]      trim;
		logic      [1:0]       output_en;
		logic      [1:0]       soft_start;
		logic      [1:0]       valley_active;
		logic      [1:0]       valley_block;
		logic      [1:0][1:0]  valley_cnt;
		logic      [15:0]      rdata;
		logic                  rvalid;
		logic                  nack;
		logic                  nvm_wr;
		logic      [7:0]       nvm_seq1;
		logic      [7:0]       nvm_seq2;
		logic      [15:0]      nvm_spare;
	} seq_state_t;

	// ------------------------------------------------------------
	// Whole state of the delay timer
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] unit_len;
		logic [31:0] tick;
		logic [2:0]  units;
		logic        busy;
		logic        done;
	} timer_state_t;

endpackage : seq_pkg

// File: core/delay_timer.sv
// Delay timer counting whole units of a programmable length.
// Assumes start_i is a one-cycle pulse with units_i nonzero.
`timescale 1ns/10ps
module delay_timer
	import seq_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        start_i,
	input  wire logic [2:0]  units_i,
	input  wire logic [31:0] unit_cycles_i,
	output logic             busy_o,
	output logic             done_o
);
	timer_state_t s;
	timer_state_t next_s;

	// ------------------------------------------------------------
	// Unit counting
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (start_i) begin
			// Unit length latched so a later change cannot stretch a running delay
			next_s.busy = 1'b1;
			next_s.units = units_i;
			next_s.unit_len = unit_cycles_i;
			next_s.tick = unit_cycles_i - 32'h00000001;
		end else if (s.busy) begin
			if (s.tick == 32'h00000000) begin
				if (s.units == 3'h1) begin
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end else begin
					next_s.units = s.units - 3'h1;
					next_s.tick = s.unit_len - 32'h00000001;
				end
			end else begin
				next_s.tick = s.tick - 32'h00000001;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign busy_o = s.busy;
	assign done_o = s.done;

endmodule : delay_timer

// File: testbench/seq_sva.sv
// Assertions of the delay sequencer: channel 1 timing, paging, registers, store.
// Assumes binding to output_on_off_delay_sequencer; inputs carry its port names.
`timescale 1ns/10ps
`include "seq_defs.svh"
module seq_sva
	import seq_pkg::*;
#(
	parameter int RAMP_CYCLES    = 4,
	parameter int TON_MIN_CYCLES = 3
)(
	input wire logic        core_clk_i,
	input wire logic        nrst_i,
	input wire logic [1:0]  enable_i,
	input wire logic [1:0]  follower_i,
	input wire logic [1:0]  page_i,
	input wire logic        cmd_wr_i,
	input wire logic        cmd_rd_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [15:0] cmd_rdata_o,
	input wire logic        cmd_rvalid_o,
	input wire logic        cmd_nack_o,
	input wire logic        store_i,
	input wire logic        nvm_load_i,
	input wire logic [15:0] nvm_spare_i,
	input wire logic        nvm_wr_o,
	input wire logic [15:0] nvm_spare_o,
	input wire logic        valley_clk_en_i,
	input wire logic [1:0]  valley_active_o,
	input wire logic [1:0]  output_en_o,
	input wire logic [1:0]  soft_start_o,
	input wire logic [1:0]  float_level_force_o,
	input wire logic [11:0] trim_o
);
	// ----
	// Helpers: valley limit bit is mirrored here since it has no port
	// ----
	localparam int FOLLOW_ON = TON_MIN_CYCLES + 2;
	int   on_age;
	int   vrun;
	logic lim_off;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			on_age  <= 0;
			vrun    <= 0;
			lim_off <= 1'b0;
		end else begin
			on_age <= enable_i[0] ? ((on_age < 1000) ? on_age + 1 : on_age) : 0;
			if (valley_clk_en_i)
				vrun <= (valley_active_o[0] && !lim_off) ? vrun + 1 : 0;
			if (cmd_wr_i && cmd_code_i == `CMD_SPARE_WORD)
				lim_off <= cmd_wdata_i[14];
			else if (nvm_load_i)
				lim_off <= nvm_spare_i[14];
		end
	end
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_off_req;
		$fell(enable_i[0]) && follower_i[0] && output_en_o[0];
	endsequence
	sequence s_seq_read;
		cmd_rd_i && cmd_code_i == `CMD_SEQ_DELAY && page_i != 2'b10 && follower_i == 2'b00;
	endsequence
	page_nack_a: assert property (cmd_wr_i && cmd_code_i == `CMD_SEQ_DELAY && page_i == 2'b10 |=> cmd_nack_o)
		else $error("write to empty page not refused");
	read_bits_a: assert property (s_seq_read |=> cmd_rvalid_o && cmd_rdata_o[15:8] == 8'h00 &&
		cmd_rdata_o[4] == 1'b0 && cmd_rdata_o[0] == 1'b0) else $error("delay read bits wrong");
	trim_ro_a: assert property (!$past(nvm_load_i) |-> $stable(trim_o))
		else $error("trim bits changed without load");
	float_level_a: assert property (cmd_wr_i && cmd_code_i == `CMD_SPARE_WORD && page_i != 2'b10
		|=> float_level_force_o == $past(cmd_wdata_i[13:12])) else $error("float level not taken");
	follow_on_a: assert property (soft_start_o[0] && follower_i[0] |-> on_age == FOLLOW_ON)
		else $error("follower turn-on delay wrong");
	follow_off_a: assert property (s_off_req |=> !output_en_o[0])
		else $error("follower turn-off delayed");
	start_pair_a: assert property ($rose(output_en_o[0]) |-> soft_start_o[0] ##1 !soft_start_o[0])
		else $error("soft-start pulse wrong");
	start_cause_a: assert property (soft_start_o[0] |-> $past(enable_i[0]))
		else $error("soft-start without enable");
	off_cause_a: assert property ($fell(output_en_o[0]) |-> !$past(enable_i[0]))
		else $error("output off while enabled");
	valley_limit_a: assert property (!lim_off |-> vrun <= 3)
		else $error("valley active too long");
	store_image_a: assert property (store_i |=> nvm_wr_o && nvm_spare_o[13:12] == $past(float_level_force_o)
		&& nvm_spare_o[11:0] == $past(trim_o)) else $error("stored image wrong");
endmodule : seq_sva

bind output_on_off_delay_sequencer seq_sva #(.RAMP_CYCLES(RAMP_CYCLES), .TON_MIN_CYCLES(TON_MIN_CYCLES))
	i_seq_sva (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .follower_i(follower_i),
		.page_i(page_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i),
		.cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
		.cmd_nack_o(cmd_nack_o), .store_i(store_i), .nvm_load_i(nvm_load_i), .nvm_spare_i(nvm_spare_i),
		.nvm_wr_o(nvm_wr_o), .nvm_spare_o(nvm_spare_o), .valley_clk_en_i(valley_clk_en_i),
		.valley_active_o(valley_active_o), .output_en_o(output_en_o), .soft_start_o(soft_start_o),
		.float_level_force_o(float_level_force_o), .trim_o(trim_o));

// File: testbench/pmbus_host_model.sv
// Host model: issues register commands and channel enable requests.
// Assumes a free-running core clock; changes its outputs only after falling edges.
`timescale 1ns/10ps
module pmbus_host_model (
	input  wire logic        core_clk_i,
	input  wire logic [1:0]  output_en_i,
	output logic      [1:0]  enable_o,
	output logic      [1:0]  page_o,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [7:0]  code_o,
	output logic      [15:0] wdata_o
);
	// ----
	// Command and enable tasks
	// ----
	initial begin
		enable_o = 2'b00;
		page_o = 2'b00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		code_o = 8'h00;
		wdata_o = 16'h0000;
	end
	task automatic access(input logic wr, input logic [1:0] page, input logic [7:0] code, input logic [15:0] data);
		@(negedge core_clk_i);
		page_o = page;
		code_o = code;
		wdata_o = data;
		wr_o = wr;
		rd_o = !wr;
		@(negedge core_clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		// Idle bus shows no stale command
		page_o = ~page_o;
		code_o = ~code_o;
		wdata_o = ~wdata_o;
	endtask : access
	task automatic set_enable(input int ch, input logic on);
		int n;
		n = 0;
		while (on && output_en_i[ch] !== 1'b0 && n < 2000) begin
			@(negedge core_clk_i);
			n++;
		end
		@(negedge core_clk_i);
		enable_o[ch] = on;
	endtask : set_enable
endmodule : pmbus_host_model

// File: testbench/testbench.sv
// Self-checking bench of the output on/off delay sequencer.
// Assumes seq_sva bound to the design and pmbus_host_model as command host.
`timescale 1ns/10ps
`include "seq_defs.svh"
module testbench;
	import seq_pkg::*;
	localparam int RAMP = 4;
	localparam int TMIN = 3;
	logic        core_clk_i, nrst_i, cmd_wr_i, cmd_rd_i, cmd_rvalid_o, cmd_nack_o, store_i, nvm_load_i;
	logic        nvm_wr_o, valley_clk_en_i;
	logic [1:0]  enable_i, follower_i, page_i, valley_req_i, valley_active_o, output_en_o, soft_start_o;
	logic [1:0]  float_level_force_o;
	logic [7:0]  cmd_code_i, nvm_seq1_i, nvm_seq2_i, nvm_seq1_o, nvm_seq2_o;
	logic [11:0] trim_o;
	logic [15:0] cmd_wdata_i, cmd_rdata_o, nvm_spare_i, nvm_spare_o, w;
	logic [15:0] exp_q[$];
	int          fail_count = 0, num_checks = 0, cycles = 0, seed, n, k;

	output_on_off_delay_sequencer #(.RAMP_CYCLES(RAMP), .TON_MIN_CYCLES(TMIN)) i_dut (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .follower_i(follower_i),
		.page_i(page_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i),
		.cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
		.cmd_nack_o(cmd_nack_o), .store_i(store_i), .nvm_load_i(nvm_load_i), .nvm_seq1_i(nvm_seq1_i),
		.nvm_seq2_i(nvm_seq2_i), .nvm_spare_i(nvm_spare_i), .nvm_wr_o(nvm_wr_o), .nvm_seq1_o(nvm_seq1_o),
		.nvm_seq2_o(nvm_seq2_o), .nvm_spare_o(nvm_spare_o), .valley_clk_en_i(valley_clk_en_i),
		.valley_req_i(valley_req_i), .valley_active_o(valley_active_o), .output_en_o(output_en_o),
		.soft_start_o(soft_start_o), .float_level_force_o(float_level_force_o), .trim_o(trim_o));
	pmbus_host_model i_host (.core_clk_i(core_clk_i), .output_en_i(output_en_o), .enable_o(enable_i),
		.page_o(page_i),
		.wr_o(cmd_wr_i), .rd_o(cmd_rd_i), .code_o(cmd_code_i), .wdata_o(cmd_wdata_i));

	// ----
	// Clock, checking and closing
	// ----
	always #5 core_clk_i = ~core_clk_i;
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task automatic rd(input logic [1:0] page, input logic [7:0] code, input logic [15:0] exp);
		exp_q.push_back(exp);
		i_host.access(1'b0, page, code, 16'h0000);
	endtask : rd
	task automatic measure(input int ch, input logic on, output int cnt);
		i_host.set_enable(ch, on);
		cnt = 0;
		do begin
			@(negedge core_clk_i);
			cnt++;
		end while ((on ? soft_start_o[ch] : !output_en_o[ch]) !== 1'b1 && cnt < 200);
	endtask : measure
	always @(negedge core_clk_i) begin
		if (cmd_rvalid_o === 1'b1)
			check("read data", cmd_rdata_o, exp_q.pop_front());
	end
	// Ceiling leaves wide room over the roughly 400 cycles of the sequence
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_sim();
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		seed = 11;
		core_clk_i = 1'b0;
		nrst_i = 1'b0;
		follower_i = 2'b00;
		store_i = 1'b0;
		nvm_load_i = 1'b0;
		nvm_seq1_i = 8'h00;
		nvm_seq2_i = 8'h00;
		nvm_spare_i = 16'h0000;
		valley_clk_en_i = 1'b0;
		valley_req_i = 2'b00;
		repeat (20) @(negedge core_clk_i);
		nrst_i = 1'b1;
		check("float level", float_level_force_o, 2'b11);
		check("output on", output_en_o, 2'b00);
		rd(2'b00, `CMD_SPARE_WORD, 16'h3000);
		rd(2'b01, `CMD_SEQ_DELAY, 16'h0000);
		w = 16'($random(seed));
		w[14] = 1'b0;
		i_host.access(1'b1, 2'b00, `CMD_SPARE_WORD, w);
		check("float level", float_level_force_o, w[13:12]);
		check("trim", trim_o, 12'h000);
		rd(2'b00, `CMD_SPARE_WORD, {w[15:12], 12'h000});
		$display("test reset and spare word done");
		for (n = 0; n < 8; n++) begin
			i_host.access(1'b1, 2'b00, `CMD_SEQ_DELAY, {8'hff, n[2:0], 1'b1, n[2:0], 1'b1});
			rd(2'b11, `CMD_SEQ_DELAY, {8'h00, n[2:0], 1'b0, n[2:0], 1'b0});
			measure(0, 1'b1, k);
			check("on delay", k, n == 0 ? 1 : n * RAMP + 2);
			measure(0, 1'b0, k);
			check("off delay", k, n == 0 ? 1 : n * RAMP + 2);
		end
		$display("test delay codes done");
		i_host.access(1'b1, 2'b11, `CMD_SEQ_DELAY, 16'h0044);
		rd(2'b01, `CMD_SEQ_DELAY, 16'h0044);
		i_host.access(1'b1, 2'b10, `CMD_SEQ_DELAY, 16'h00ee);
		check("empty page refusal", cmd_nack_o, 1'b1);
		rd(2'b00, `CMD_SEQ_DELAY, 16'h0044);
		i_host.set_enable(1, 1'b1);
		repeat (3) @(negedge core_clk_i);
		i_host.set_enable(1, 1'b0);
		repeat (15) @(negedge core_clk_i);
		check("aborted turn-on", output_en_o[1], 1'b0);
		$display("test paging done");
		follower_i = 2'b01;
		i_host.access(1'b1, 2'b00, `CMD_SEQ_DELAY, 16'h00e2);
		check("follower refusal", cmd_nack_o, 1'b1);
		rd(2'b00, `CMD_SEQ_DELAY, 16'h0000);
		check("follower read refusal", cmd_nack_o, 1'b1);
		i_host.access(1'b1, 2'b11, `CMD_SEQ_DELAY, 16'h00e2);
		check("follower page both", cmd_nack_o, 1'b1);
		measure(0, 1'b1, k);
		check("follower on delay", k, TMIN + 2);
		measure(0, 1'b0, k);
		check("follower off delay", k, 1);
		follower_i = 2'b00;
		rd(2'b00, `CMD_SEQ_DELAY, 16'h0044);
		rd(2'b01, `CMD_SEQ_DELAY, 16'h00e2);
		$display("test follower done");
		store_i = 1'b1;
		@(negedge core_clk_i);
		store_i = 1'b0;
		check("store strobe", nvm_wr_o, 1'b1);
		check("stored delay", nvm_seq1_o, 8'h44);
		check("stored delay 2", nvm_seq2_o, 8'he2);
		check("stored spare", nvm_spare_o, {w[15:12], 12'h000});
		nvm_spare_i = 16'h3abc;
		nvm_seq1_i = 8'h20;
		nvm_load_i = 1'b1;
		@(negedge core_clk_i);
		nvm_load_i = 1'b0;
		check("loaded float", float_level_force_o, 2'b11);
		check("loaded trim", trim_o, 12'habc);
		rd(2'b00, `CMD_SEQ_DELAY, 16'h0020);
		rd(2'b01, `CMD_SEQ_DELAY, 16'h0000);
		$display("test store and load done");
		valley_clk_en_i = 1'b1;
		valley_req_i = 2'b11;
		k = 0;
		repeat (12) begin
			@(negedge core_clk_i);
			k += (valley_active_o[0] === 1'b1);
		end
		// Three steps active, two blocked, retrigger: half of twelve steps
		check("valley seen", k, 6);
		valley_req_i = 2'b00;
		i_host.access(1'b1, 2'b00, `CMD_SPARE_WORD, w | 16'h4000);
		repeat (8) begin
			w[1:0] = 2'($random(seed));
			valley_req_i = w[1:0];
			@(negedge core_clk_i);
			check("valley follow", valley_active_o, w[1:0]);
		end
		$display("test valley done");
		@(negedge core_clk_i);
		check("pending reads", exp_q.size(), 16'h0000);
		end_sim();
	end
endmodule : testbench
